/* rst_src_pkg.sv */
// constants for the reset source controller
package rst_src_pkg;
	localparam int CLK_HZ = 25000000;
	localparam logic [7:0] VSEL_POR = 8'h55;
	localparam logic [7:0] VSEL_2V55 = 8'h33;
	localparam logic [7:0] VSEL_3V15 = 8'h99;
	localparam logic [7:0] VSEL_3V80 = 8'haa;
	localparam logic [4:0] WDSEL_EN = 5'h0a;
	localparam logic [4:0] WDSEL_DIS = 5'h15;
	localparam logic [4:0] WDSEL_POR = 5'h0a;
	// word offsets on the bus (byte addresses)
	localparam logic [3:0] OFS_VSEL = 4'h0;
	localparam logic [3:0] OFS_CAUSE = 4'h4;
	localparam logic [3:0] OFS_IRQ_STAT = 4'h8;
	localparam logic [3:0] OFS_IRQ_MASK = 4'hc;
	// cause register bit positions
	localparam int CB_WDSEL = 0;
	localparam int CB_VSEL = 1;
	localparam int CB_LOWV = 2;
	localparam int CB_TMO = 3;
	localparam int CB_PWRDN = 4;
	// slow oscillator edges from request to reset: 2 or 3
	localparam logic [1:0] SLOW_DLY = 2'd2;
	// qualification time in ns and its cycle count (least time, rounded up)
	localparam int LOWV_QUAL_NS = 1000;
	localparam int LOWV_QUAL_CYC = (LOWV_QUAL_NS * (CLK_HZ / 1000000) + 999) / 1000;
	// start-up delays in clocks of the selected source
	localparam logic [7:0] STARTUP_FAST = 8'd16;
	localparam logic [7:0] STARTUP_XTAL = 8'd128;
	localparam logic [7:0] STARTUP_SLOW = 8'd2;
	typedef enum logic [1:0] {
		CK_FAST = 2'b00,
		CK_XTAL = 2'b01,
		CK_SLOW = 2'b10
	} clk_src_t;
	typedef enum logic [1:0] {
		ST_RUN = 2'b00,
		ST_ARM = 2'b01,
		ST_HOLD = 2'b10
	} seq_state_t;
endpackage : rst_src_pkg

/* rst_src_ctrl.sv */
// reset source controller with wishbone registers
`timescale 1ns/10ps
`default_nettype none
module rst_src_ctrl #(
	parameter int QUAL_CYC = rst_src_pkg::LOWV_QUAL_CYC
) (
	input wire logic clk_i, // 25 MHz system clock
	input wire logic rst_i, // power-on reset, sync, high
	input wire logic ext_reset_pin_n_i, // external reset pin, low active
	input wire logic lowv_detect_i, // supply below selected threshold
	input wire logic slow_osc_i, // slow internal oscillator
	input wire logic powerdown_i, // device in power-down
	input wire logic sleep_idle_i, // device in sleep or idle
	input wire logic wd_timeout_i, // watchdog time-out pulse
	input wire logic [4:0] wd_enable_field_i, // watchdog enable field
	input wire logic [1:0] clk_src_i, // active system clock source
	input wire logic sys_clk_tick_i, // one pulse per system clock of that source
	input wire logic wb_cyc_i, // wishbone cycle
	input wire logic wb_stb_i, // wishbone strobe
	input wire logic wb_we_i, // wishbone write
	input wire logic [3:0] wb_adr_i, // wishbone byte address
	input wire logic [3:0] wb_sel_i, // wishbone byte lanes
	input wire logic [31:0] wb_dat_i, // wishbone write data
	output logic [31:0] wb_dat_o, // wishbone read data
	output logic wb_ack_o, // wishbone ack
	output logic sys_reset_o, // merged full reset, high
	output logic pc_sp_clear_o, // pulse: clear pc and stack only
	output logic por_init_o, // power-on initialisation pulse
	output logic [7:0] volt_level_select_o, // threshold code to detector
	output logic irq_o // level interrupt
);
	typedef struct packed {
		logic [1:0] pin_s;
		logic [1:0] lv_s;
		logic [2:0] osc_s;
		rst_src_pkg::seq_state_t st;
		logic [1:0] slow_cnt;
		logic [7:0] start_cnt;
		logic [15:0] qual_cnt;
		logic lowv_pend;
		logic vsel_pend;
		logic wdsel_pend;
		logic [7:0] vsel;
		logic [4:0] cause;
		logic [4:0] istat;
		logic [4:0] imask;
		logic [31:0] rdata;
		logic ack;
		logic pcsp;
		logic por;
	} state_t;

	state_t cur_q, nxt_d;

	function automatic logic vsel_valid(input logic [7:0] v);
		return v == rst_src_pkg::VSEL_POR || v == rst_src_pkg::VSEL_2V55 ||
			v == rst_src_pkg::VSEL_3V15 || v == rst_src_pkg::VSEL_3V80;
	endfunction : vsel_valid

	function automatic logic [7:0] start_len(input logic [1:0] src);
		unique case (src)
			rst_src_pkg::CK_XTAL: begin
				return rst_src_pkg::STARTUP_XTAL;
			end
			rst_src_pkg::CK_SLOW: begin
				return rst_src_pkg::STARTUP_SLOW;
			end
			default: begin
				return rst_src_pkg::STARTUP_FAST; // unused code treated as fast
			end
		endcase
	endfunction : start_len

	function automatic logic reg_wr(input logic w, input logic [3:0] adr, input logic [3:0] ofs);
		return w && (adr == ofs);
	endfunction : reg_wr

	function automatic logic [31:0] read_word(
		input logic [3:0] adr,
		input logic [7:0] vsel,
		input logic [4:0] cause,
		input logic [4:0] istat,
		input logic [4:0] imask
	);
		unique case (adr)
			rst_src_pkg::OFS_VSEL: begin
				return {24'h0, vsel};
			end
			rst_src_pkg::OFS_CAUSE: begin
				return {27'h0, cause};
			end
			rst_src_pkg::OFS_IRQ_STAT: begin
				return {27'h0, istat};
			end
			rst_src_pkg::OFS_IRQ_MASK: begin
				return {27'h0, imask};
			end
			default: begin
				return 32'h0; // unmapped words read zero
			end
		endcase
	endfunction : read_word

	logic pin_low, lowv_sync, slow_edge, wr, rd_en, wd_run, wd_sleep, bad_wdsel, any_slow_req;
	logic [1:0] slow_next;
	logic [7:0] start_next;
	logic [4:0] ev;

	always_comb begin
		pin_low = ~cur_q.pin_s[1];
		lowv_sync = cur_q.lv_s[1];
		slow_edge = cur_q.osc_s[1] & ~cur_q.osc_s[2];
		// write lands at the edge where the master samples ack high
		wr = wb_cyc_i & wb_stb_i & wb_we_i & cur_q.ack & wb_sel_i[0];
		slow_next = cur_q.slow_cnt + 2'd1;
		start_next = cur_q.start_cnt + 8'd1;
		rd_en = wb_cyc_i & wb_stb_i & ~cur_q.ack;
		wd_run = wd_timeout_i & ~sleep_idle_i & (cur_q.st == rst_src_pkg::ST_RUN);
		wd_sleep = wd_timeout_i & sleep_idle_i & (cur_q.st == rst_src_pkg::ST_RUN);
		bad_wdsel = wd_enable_field_i != rst_src_pkg::WDSEL_EN && wd_enable_field_i != rst_src_pkg::WDSEL_DIS;
		nxt_d = cur_q;
		nxt_d.pin_s = {cur_q.pin_s[0], ext_reset_pin_n_i};
		nxt_d.lv_s = {cur_q.lv_s[0], lowv_detect_i};
		nxt_d.osc_s = {cur_q.osc_s[1:0], slow_osc_i};
		nxt_d.pcsp = 1'b0;
		nxt_d.por = 1'b0;
		ev = '0;
		// qualification: low supply must outlast the count, power-down suspends detection
		if (lowv_sync && !powerdown_i) begin
			if (cur_q.qual_cnt < 16'(QUAL_CYC))
				nxt_d.qual_cnt = cur_q.qual_cnt + 16'd1;
			else if (!cur_q.lowv_pend && cur_q.st == rst_src_pkg::ST_RUN) begin
				nxt_d.lowv_pend = 1'b1;
				ev[rst_src_pkg::CB_LOWV] = 1'b1;
			end
		end else begin
			nxt_d.qual_cnt = '0;
		end
		if (!vsel_valid(cur_q.vsel) && !cur_q.vsel_pend && cur_q.st == rst_src_pkg::ST_RUN) begin
			nxt_d.vsel_pend = 1'b1;
			ev[rst_src_pkg::CB_VSEL] = 1'b1;
		end
		if (bad_wdsel && !cur_q.wdsel_pend && cur_q.st == rst_src_pkg::ST_RUN) begin
			nxt_d.wdsel_pend = 1'b1;
			ev[rst_src_pkg::CB_WDSEL] = 1'b1;
		end
		if (wd_run) begin
			ev[rst_src_pkg::CB_TMO] = 1'b1;
		end
		if (wd_sleep) begin
			// sleep time-out: no full reset, only pc and stack cleared
			ev[rst_src_pkg::CB_TMO] = 1'b1;
			ev[rst_src_pkg::CB_PWRDN] = 1'b1;
			nxt_d.pcsp = 1'b1;
		end
		any_slow_req = nxt_d.lowv_pend | nxt_d.vsel_pend | nxt_d.wdsel_pend;
		// reset sequencer
		unique case (cur_q.st)
			rst_src_pkg::ST_RUN: begin
				if (pin_low || wd_run) begin
					// pin and run time-out skip the slow-clock wait
					nxt_d.st = rst_src_pkg::ST_HOLD;
					nxt_d.start_cnt = '0;
				end else if (any_slow_req) begin
					nxt_d.st = rst_src_pkg::ST_ARM;
					nxt_d.slow_cnt = '0;
				end else begin
					nxt_d.st = rst_src_pkg::ST_RUN;
				end
			end
			rst_src_pkg::ST_ARM: begin
				if (pin_low) begin
					nxt_d.st = rst_src_pkg::ST_HOLD;
					nxt_d.start_cnt = '0;
				end else if (slow_edge) begin
					nxt_d.slow_cnt = slow_next;
					if (slow_next >= rst_src_pkg::SLOW_DLY) begin
						nxt_d.st = rst_src_pkg::ST_HOLD;
						nxt_d.start_cnt = '0;
					end
				end
			end
			rst_src_pkg::ST_HOLD: begin
				// only power-on and the invalid-code reset reload the select register
				if (cur_q.vsel_pend) nxt_d.vsel = rst_src_pkg::VSEL_POR;
				nxt_d.lowv_pend = 1'b0;
				nxt_d.vsel_pend = 1'b0;
				nxt_d.wdsel_pend = 1'b0;
				if (pin_low) begin
					// a pin held low keeps restarting the delay
					nxt_d.start_cnt = '0;
				end else if (sys_clk_tick_i) begin
					nxt_d.start_cnt = start_next;
					if (start_next >= start_len(clk_src_i)) begin
						nxt_d.st = rst_src_pkg::ST_RUN;
					end
				end
			end
			default: begin
				nxt_d.st = rst_src_pkg::ST_HOLD;
			end
		endcase
		// hardware set wins over software clear (write one to status, write zero to cause)
		nxt_d.istat = cur_q.istat | ev;
		// select writes during the reset hold would fight the invalid-code reload
		if (reg_wr(wr, wb_adr_i, rst_src_pkg::OFS_VSEL) && cur_q.st != rst_src_pkg::ST_HOLD) begin
			nxt_d.vsel = wb_dat_i[7:0];
		end
		if (reg_wr(wr, wb_adr_i, rst_src_pkg::OFS_CAUSE)) begin
			nxt_d.cause = cur_q.cause & wb_dat_i[4:0];
		end
		if (reg_wr(wr, wb_adr_i, rst_src_pkg::OFS_IRQ_STAT)) begin
			nxt_d.istat = (cur_q.istat & ~wb_dat_i[4:0]) | ev;
		end
		if (reg_wr(wr, wb_adr_i, rst_src_pkg::OFS_IRQ_MASK)) begin
			nxt_d.imask = wb_dat_i[4:0];
		end
		nxt_d.cause = nxt_d.cause | ev;
		nxt_d.ack = rd_en;
		nxt_d.rdata = read_word(wb_adr_i, cur_q.vsel, cur_q.cause, cur_q.istat, cur_q.imask);
		if (rst_i) begin
			nxt_d = '0;
			nxt_d.pin_s = 2'b11;
			nxt_d.st = rst_src_pkg::ST_HOLD;
			nxt_d.vsel = rst_src_pkg::VSEL_POR;
			nxt_d.por = 1'b1;
			// every cause flag, time-out and power-down included, cleared
			nxt_d.cause = '0;
		end
	end

	always_ff @(posedge clk_i) begin
		cur_q <= nxt_d;
	end

	assign wb_dat_o = cur_q.rdata;
	assign wb_ack_o = cur_q.ack;
	assign sys_reset_o = cur_q.st == rst_src_pkg::ST_HOLD;
	assign pc_sp_clear_o = cur_q.pcsp;
	assign por_init_o = cur_q.por;
	assign volt_level_select_o = cur_q.vsel;
	assign irq_o = |(cur_q.istat & cur_q.imask);

	initial begin
		// the qualification counter is 16 bits wide
		assert (QUAL_CYC > 0 && QUAL_CYC < 65536) else $error("QUAL_CYC out of range");
		// the slow-clock wait must stay inside its two to three edge window
		assert (rst_src_pkg::SLOW_DLY >= 2'd2 && rst_src_pkg::SLOW_DLY <= 2'd3)
			else $error("SLOW_DLY out of range");
		// a start-up length of zero would release the reset on the first tick, like a length of one
		assert (rst_src_pkg::STARTUP_FAST != 8'd0 && rst_src_pkg::STARTUP_XTAL != 8'd0 &&
			rst_src_pkg::STARTUP_SLOW != 8'd0)
			else $error("start-up length of zero");
	end
endmodule : rst_src_ctrl
`default_nettype wire

/* supply_model.sv */
// model of the reset pin, supply monitor and slow oscillator
`timescale 1ns/10ps
`default_nettype none
module supply_model (
	input wire logic clk_i, // system clock
	input wire logic pin_low_i, // hold the pin low
	input wire logic sag_i, // supply below threshold
	output logic reset_pin_n_o, // pin, pulled up when released
	output logic lowv_o, // monitor output
	output logic slow_osc_o // slow oscillator, clk_i/4
);
	logic [1:0] div_q = 2'h0;
	assign reset_pin_n_o = ~pin_low_i;
	assign lowv_o = sag_i;
	assign slow_osc_o = div_q[1];
	always_ff @(posedge clk_i) div_q <= div_q + 2'h1;
endmodule : supply_model
`default_nettype wire

/* rst_src_ctrl_chk.sv */
// port checker for the reset source controller
`timescale 1ns/10ps
`default_nettype none
module rst_src_chk (
	input wire logic clk_i, // clock
	input wire logic rst_i, // reset
	input wire logic ext_reset_pin_n_i, // pin
	input wire logic sleep_idle_i, // sleep
	input wire logic wd_timeout_i, // time-out
	input wire logic wb_cyc_i, // cycle
	input wire logic wb_stb_i, // strobe
	input wire logic wb_we_i, // write
	input wire logic wb_ack_o, // ack
	input wire logic sys_reset_o, // reset out
	input wire logic pc_sp_clear_o, // pc clear
	input wire logic [7:0] volt_level_select_o // select
);
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);
	property p_ack; wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o; endproperty
	a_ack: assert property (p_ack) else $error("no ack"); // [bus]
	property p_ack_drop; wb_ack_o |=> !wb_ack_o; endproperty
	a_ack_drop: assert property (p_ack_drop) else $error("ack held"); // [bus]
	property p_por; $fell(rst_i) |-> sys_reset_o && volt_level_select_o == 8'h55; endproperty
	a_por: assert property (p_por) else $error("bad power-on state");
	property p_pin; !ext_reset_pin_n_i |-> ##[0:5] sys_reset_o; endproperty
	a_pin: assert property (p_pin) else $error("pin reset missing");
	property p_wd_run; wd_timeout_i && !sleep_idle_i |-> ##[1:3] sys_reset_o; endproperty
	a_wd_run: assert property (p_wd_run) else $error("run time-out no reset");
	property p_wd_slp; wd_timeout_i && sleep_idle_i && !sys_reset_o |-> ##[1:3] pc_sp_clear_o; endproperty
	a_wd_slp: assert property (p_wd_slp) else $error("no pc clear");
	property p_slp_keep; wd_timeout_i && sleep_idle_i && !sys_reset_o |=> !sys_reset_o [*3]; endproperty
	a_slp_keep: assert property (p_slp_keep) else $error("sleep time-out reset");
	property p_vsel; $changed(volt_level_select_o) |-> volt_level_select_o == 8'h55 || $past(wb_cyc_i && wb_we_i);
	endproperty
	a_vsel: assert property (p_vsel) else $error("select changed");
endmodule : rst_src_chk
bind rst_src_ctrl rst_src_chk chk (.clk_i, .rst_i, .ext_reset_pin_n_i, .sleep_idle_i, .wd_timeout_i, .wb_cyc_i,
	.wb_stb_i, .wb_we_i, .wb_ack_o, .sys_reset_o, .pc_sp_clear_o, .volt_level_select_o);
`default_nettype wire

/* tb_top.sv */
// self-checking bench for the reset source controller
`timescale 1ns/10ps
`default_nettype none
module tb_top;
	logic clk_i = 1'b0, rst_i = 1'b1, pd = 1'b0, sl = 1'b0, wd_to = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0;
	logic pin_low = 1'b0, sag = 1'b0, ack, srst, pcsp, irq, pin_n, lowv, sosc, por;
	logic [1:0] csrc = 2'h0;
	logic [3:0] adr = 4'h0;
	logic [31:0] dat = 32'h0, rdat, q;
	logic [7:0] vsel;
	logic [4:0] wden = rst_src_pkg::WDSEL_EN;
	int num_errors = 0, checks_done = 0, ncyc = 0, nrel;
	always #20 clk_i = ~clk_i;
	supply_model sm (.clk_i, .pin_low_i(pin_low), .sag_i(sag), .reset_pin_n_o(pin_n), .lowv_o(lowv), .slow_osc_o(sosc));
	rst_src_ctrl #(.QUAL_CYC(2)) uut (.clk_i, .rst_i, .ext_reset_pin_n_i(pin_n), .lowv_detect_i(lowv),
		.slow_osc_i(sosc), .powerdown_i(pd), .sleep_idle_i(sl), .wd_timeout_i(wd_to), .wd_enable_field_i(wden),
		.clk_src_i(csrc), .sys_clk_tick_i(1'b1), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
		.wb_sel_i(4'hf), .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack), .sys_reset_o(srst),
		.pc_sp_clear_o(pcsp), .por_init_o(por), .volt_level_select_o(vsel), .irq_o(irq));
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		checks_done++;
		if (s !== e) begin
			num_errors++;
			$display("BAD t=%0t seen %h exp %h", $time, s, e);
		end
	endtask : chk
	task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
		@(posedge clk_i);
		{cyc, stb, we, adr, dat} <= {2'b11, w, a, d};
		do @(posedge clk_i); while (ack !== 1'b1);
		q = rdat;
		{cyc, stb} <= 2'b00;
	endtask : bus
	task automatic rel();
		nrel = 0;
		while (srst !== 1'b0 && nrel < 300) begin
			@(posedge clk_i);
			nrel++;
		end
	endtask : rel
	task automatic hit(input int n);
		int i;
		i = 0;
		while (srst !== 1'b1 && i < n) begin
			@(posedge clk_i);
			i++;
		end
		chk(srst, 1'b1);
		// drop the pin, the low supply and the bad enable field once reset is seen so none fires again on release
		{pin_low, sag} <= 2'b00;
		wden <= rst_src_pkg::WDSEL_EN;
		rel();
	endtask : hit
	task automatic pulse();
		@(posedge clk_i) wd_to <= 1'b1;
		@(posedge clk_i) wd_to <= 1'b0;
	endtask : pulse
	task automatic t_por();
		chk(por, 1'b1);
		rel();
		chk(nrel >= 16 && nrel <= 20, 1'b1);
		chk(por, 1'b0);
		bus(0, 4'h0, 0);
		chk(q[7:0], 8'h55);
		bus(0, 4'h4, 0);
		chk(q[4:3], 2'b00);
		$display("test por done");
	endtask : t_por
	task automatic t_run();
		bus(1, 4'h0, 32'h33);
		bus(0, 4'h0, 0);
		chk(q[7:0], 8'h33);
		pulse();
		hit(6);
		bus(0, 4'h0, 0);
		chk(q[7:0], 8'h33);
		bus(0, 4'h4, 0);
		chk(q[4:3], 2'b01);
		$display("test run time-out done");
	endtask : t_run
	task automatic t_sleep();
		int i;
		sl <= 1'b1;
		pulse();
		for (i = 0; i < 4 && pcsp !== 1'b1; i++) @(posedge clk_i);
		chk(pcsp, 1'b1);
		chk(srst, 1'b0);
		sl <= 1'b0;
		bus(0, 4'h4, 0);
		chk(q[4:3], 2'b11);
		bus(1, 4'h4, 0);
		bus(0, 4'h4, 0);
		chk(q[4:0], 5'h00);
		bus(1, 4'hc, 32'h1f);
		@(posedge clk_i);
		chk(irq, 1'b1); // [irq]
		bus(1, 4'h8, 32'h1f);
		@(posedge clk_i);
		chk(irq, 1'b0); // [irq]
		$display("test sleep time-out done");
	endtask : t_sleep
	task automatic t_bad();
		bus(1, 4'h0, 32'h12);
		hit(60);
		bus(0, 4'h0, 0);
		chk(q[7:0], 8'h55);
		bus(0, 4'h4, 0);
		chk(q[1], 1'b1);
		@(posedge clk_i) wden <= 5'h00;
		hit(60);
		bus(0, 4'h4, 0);
		chk(q[0], 1'b1);
		$display("test bad select done");
	endtask : t_bad
	task automatic t_lowv();
		@(posedge clk_i) sag <= 1'b1;
		@(posedge clk_i) sag <= 1'b0;
		repeat (40) @(posedge clk_i);
		chk(srst, 1'b0);
		{pd, sag} <= 2'b11;
		repeat (40) @(posedge clk_i);
		chk(srst, 1'b0);
		pd <= 1'b0;
		hit(60);
		bus(0, 4'h4, 0);
		chk(q[2], 1'b1);
		@(posedge clk_i) pin_low <= 1'b1;
		hit(6);
		chk(nrel >= 16 && nrel <= 22, 1'b1);
		$display("test low supply and pin done");
	endtask : t_lowv
	task automatic t_src();
		@(posedge clk_i) {csrc, pin_low} <= {rst_src_pkg::CK_SLOW, 1'b1};
		hit(6);
		chk(nrel >= 3 && nrel <= 6, 1'b1);
		@(posedge clk_i) {csrc, pin_low} <= {rst_src_pkg::CK_XTAL, 1'b1};
		hit(6);
		chk(nrel >= 128 && nrel <= 134, 1'b1);
		csrc <= rst_src_pkg::CK_FAST;
		$display("test start-up delay by source done");
	endtask : t_src
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", checks_done, num_errors);
		if (num_errors == 0 && checks_done > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask : report_and_stop
	always @(posedge clk_i) begin
		ncyc++;
		if (ncyc == 20000) begin
			num_errors++;
			report_and_stop();
		end
	end
	initial begin
		repeat (4) @(posedge clk_i);
		rst_i <= 1'b0;
		t_por();
		t_run();
		t_sleep();
		t_bad();
		t_lowv();
		t_src();
		report_and_stop();
	end
endmodule : tb_top
`default_nettype wire
